// ===== common/icv_pkg.sv
// shared constants for the current calibration and overvoltage limit command registers
package icv_pkg;
    // command codes and the all-phase selector
    localparam logic [7:0]  CMD_GAIN       = 8'h38;
    localparam logic [7:0]  CMD_OFFSET     = 8'h39;
    localparam logic [7:0]  CMD_OVF        = 8'h40;
    localparam logic [7:0]  PHASE_ALL      = 8'hFF;
    // internal fixed point: signed, 16 fraction bits
    localparam int          VAL_W          = 48;
    localparam int          FRAC           = 16;
    localparam logic [4:0]  EXP_BIAS_FLIP  = 5'h10;  // exponent + 16, modulo 32
    // gain trim: reset is exponent -7, mantissa 128, i.e. exactly one
    localparam logic [15:0] GAIN_RESET     = 16'hC880;
    localparam logic [4:0]  GAIN_Q_EXP     = 5'h1A;  // -6, steps of 1/64
    localparam logic [10:0] GAIN_Q_MAN_MAX = 11'h07F;  // 127/64 = 1.984
    localparam logic [VAL_W-1:0] GAIN_MAX_Q = 48'h0000_0001_FC00;
    localparam logic [VAL_W-1:0] GAIN_RND  = 48'h0000_0000_0200;
    localparam int          GAIN_RND_SH    = 10;
    localparam int          GAIN_USE_W     = 18;
    // offset trim: reset exponent -4, stored steps of 1/16
    localparam logic [4:0]  OFS_Q_EXP      = 5'h1C;
    localparam logic [15:0] OFS_RESET      = 16'hE000;
    localparam logic [VAL_W-1:0] OFS_RND   = 48'h0000_0000_0800;
    localparam int          OFS_RND_SH     = 12;
    // overvoltage limit: relative format has 1.0 = 512, reset 614 -> 120 %
    localparam logic [15:0] OVF_RESET      = 16'h0266;
    localparam logic [15:0] REL_ONE        = 16'h0200;
    localparam logic [3:0]  FINE_RESET     = 4'h6;
    localparam logic [1:0]  COARSE_RESET   = 2'h1;
    localparam logic [3:0]  FINE_LAST      = 4'hE;
    localparam logic [1:0]  COARSE_LAST    = 2'h3;
    localparam logic [31:0] PCT_SCALE      = 32'h0000_03E8;  // percent in tenths, x1000
    localparam logic [10:0] PCT_FINE_BASE  = 11'h41A;  // 105.0 %
    localparam logic [10:0] PCT_FINE_STEP  = 11'h019;  // 2.5 %
    localparam logic [10:0] PCT_CRS_BASE   = 11'h44C;  // 110 %
    localparam logic [10:0] PCT_CRS_STEP   = 11'h064;  // 10 %
    localparam logic [10:0] PCT_MAX        = 11'h578;  // 140 %
    // overvoltage response field
    localparam int          RESP_HI        = 7;
    localparam int          RESP_LO        = 6;
    localparam logic [1:0]  RESP_IGNORE    = 2'h0;
    localparam logic [1:0]  RESP_INVALID   = 2'h3;

    // overvoltage watch states, gray along watch -> flagged -> off
    typedef enum logic [1:0] {
        OVS_WATCH = 2'h0,
        OVS_FLAG  = 2'h1,
        OVS_OFF   = 2'h3
    } icv_ovs_e;

    function automatic logic [10:0] pct_fine(input logic [3:0] idx);
        pct_fine = 11'(PCT_FINE_BASE + 11'(idx) * PCT_FINE_STEP);
    endfunction : pct_fine

    function automatic logic [10:0] pct_coarse(input logic [1:0] idx);
        pct_coarse = 11'(PCT_CRS_BASE + 11'(idx) * PCT_CRS_STEP);
    endfunction : pct_coarse
endpackage : icv_pkg

// ===== rtl/icv_lin11_dec.sv
// signed linear-11 word to signed fixed point decoder
`timescale 1ns/1ps
module icv_lin11_dec
    import icv_pkg::*;
(
    input  wire logic [15:0]             word_in,   // exponent 15:11, mantissa 10:0
    output logic signed [VAL_W-1:0]      value_out  // value with FRAC fraction bits
);
    // exponent ranges -16..15, so exponent+16 is always a left shift of 0..31
    wire logic [4:0] shift_amt = word_in[15:11] ^ EXP_BIAS_FLIP;
    wire logic signed [VAL_W-1:0] man_ext = VAL_W'($signed(word_in[10:0]));

    // mantissa times two to the exponent [R21]
    assign value_out = man_ext <<< shift_amt;  // [R21]
endmodule : icv_lin11_dec

// ===== rtl/icv_ov_map.sv
// maps an overvoltage limit word onto the hardware percentage steps
`timescale 1ns/1ps
module icv_ov_map
    import icv_pkg::*;
(
    input  wire logic [15:0] limit_in,      // limit word, relative or absolute
    input  wire logic [15:0] vout_cmd_in,   // present output voltage command
    input  wire logic        abs_mode_in,   // high for absolute format
    output logic [3:0]       fine_idx_out,  // 2.5 % step index while converting
    output logic [1:0]       coarse_idx_out, // 10 % step index while stopped
    output logic             valid_out      // limit fits within the hardware span
);
    logic [31:0] base;
    logic [31:0] lim_k;

    // smallest step that is not below the limit, else the last step: rounding goes up for limits up to 140 % [R18] [R19]
    always_comb begin
        base = abs_mode_in ? {16'h0000, vout_cmd_in} : {16'h0000, REL_ONE};
        lim_k = 32'({16'h0000, limit_in} * PCT_SCALE);
        fine_idx_out = FINE_LAST;
        coarse_idx_out = COARSE_LAST;
        for (int k = 14; k >= 0; k--) begin
            if (32'(base * {21'h0, pct_fine(4'(k))}) >= lim_k) begin
                fine_idx_out = 4'(k);  // [R18]
            end
        end
        for (int j = 3; j >= 0; j--) begin
            if (32'(base * {21'h0, pct_coarse(2'(j))}) >= lim_k) begin
                coarse_idx_out = 2'(j);  // [R19]
            end
        end
        // above 140 % or against a zero command the write is refused [R04]
        valid_out = (base != 32'h0) && (32'(base * {21'h0, PCT_MAX}) >= lim_k);
    end
endmodule : icv_ov_map

// ===== rtl/icv_regs.sv
// current gain/offset trim and output overvoltage fault limit command registers
//
// Operation
// [R01] gain word 38h scales sensed current for report
// [R02] gain is unitless, resets to exactly one
// [R03] gain change rescales overcurrent fault and warning
// [R04] out-of-range writes flag invalid data, alert host
// [R05] store/restore rounds gain to 1/64, max 1.984
// [R06] live gain writes keep full linear resolution
// [R07] phased offset word 39h adds to report
// [R08] stack offset is sum of per-phase offsets
// [R09] restore reloads offset step saved at store
// [R10] fine offset writes accepted inside min/max span
// [R11] phase 00h-03h addresses that phase only
// [R12] phase FFh write splits total across phases
// [R13] phase FFh read returns phase 0 times count
// [R14] limit word 40h applied relative to command
// [R15] absolute limit word kept, threshold tracks command
// [R16] overvoltage compare runs from reset, even stopped
// [R17] fault takes action from response setting
// [R18] converting: round up, 105-140 % in 2.5 %
// [R19] stopped: 110-140 % in 10 % steps
// [R20] fault sets status bits and raises alert
// [R21] linear word is mantissa times two^exponent
`timescale 1ns/1ps
module icv_regs
    import icv_pkg::*;
#(
    parameter int                 NPH     = 4,                     // phases in the stack
    parameter logic [VAL_W-1:0]   OFS_MAX = 48'h0000_0010_0000     // offset span, +/-16 A
) (
    input  wire logic        ref_clk_in,          // 100 MHz clock
    input  wire logic        nrst_in,             // synchronous reset, active low
    input  wire logic        cmd_valid_in,        // one decoded bus command this cycle
    input  wire logic        cmd_write_in,        // high write, low read
    input  wire logic [7:0]  cmd_code_in,         // command code
    input  wire logic [15:0] cmd_data_in,         // write word
    input  wire logic [7:0]  phase_sel_in,        // phase selector
    input  wire logic        nvm_store_in,        // store pulse
    input  wire logic        nvm_restore_in,      // restore pulse
    input  wire logic        clear_faults_in,     // clears status bits
    input  wire logic [31:0] iout_sense_in,       // sensed current, signed, 16 fraction bits
    input  wire logic [31:0] oc_fault_limit_in,   // overcurrent fault limit, same scale
    input  wire logic [31:0] oc_warn_limit_in,    // overcurrent warning limit
    input  wire logic        vout_abs_mode_in,    // output voltage format is absolute
    input  wire logic [15:0] vout_command_in,     // output voltage command
    input  wire logic [15:0] vout_sense_in,       // sensed output voltage, command scale
    input  wire logic        converting_in,       // output conversion enabled
    input  wire logic [7:0]  ov_response_in,      // overvoltage response byte
    output logic [15:0]      rd_data_out,         // read word
    output logic             rd_valid_out,        // read word valid, one cycle
    output logic [31:0]      iout_report_out,     // reported current
    output logic [31:0]      offset_sum_out,      // stack offset sum
    output logic             oc_fault_out,        // reported current above fault limit
    output logic             oc_warn_out,         // reported current above warning limit
    output logic [10:0]      ov_pct_out,          // enforced threshold, tenths of percent
    output logic             ov_fault_out,        // overvoltage present
    output logic             ov_shutdown_out,     // shutdown requested by response
    output logic             status_byte_ov_out,  // status byte overvoltage bit
    output logic             status_word_vout_out, // status word output voltage bit
    output logic             status_overvoltage_limit_value_out, // output voltage status fault bit
    output logic             status_cml_out,      // invalid data flag
    output logic             alert_out            // host alert
);
    // saturate a signed value into an 11-bit mantissa
    function automatic logic [10:0] sat11(input logic signed [VAL_W-1:0] v);
        if (v > 48'sd1023) begin
            sat11 = 11'h3FF;
        end else if (v < -48'sd1024) begin
            sat11 = 11'h400;
        end else begin
            sat11 = v[10:0];
        end
    endfunction : sat11

    // registers
    logic [15:0]      gain_q, gain_d, gain_nvm_q, gain_nvm_d;
    logic [15:0]      ofs_q [NPH];
    logic [15:0]      ofs_d [NPH];
    logic [15:0]      ofs_nvm_q [NPH];
    logic [15:0]      ofs_nvm_d [NPH];
    logic [15:0]      ovf_q;
    logic [3:0]       fine_q;
    logic [1:0]       coarse_q;
    icv_ovs_e         ovs_q, ovs_d;
    logic             ov_now_q, shut_q, st_ov_q, st_cml_q, alert_q;

    // decoding
    logic signed [VAL_W-1:0] wr_val, gain_val;
    logic signed [VAL_W-1:0] ofs_val [NPH];
    logic [3:0]  map_fine;
    logic [1:0]  map_coarse;
    logic        map_ok;

    wire logic wr      = cmd_valid_in & cmd_write_in;
    wire logic wr_gain = wr & (cmd_code_in == CMD_GAIN);
    wire logic wr_ofs  = wr & (cmd_code_in == CMD_OFFSET);
    wire logic wr_ovf  = wr & (cmd_code_in == CMD_OVF);
    wire logic sel_all = (phase_sel_in == PHASE_ALL);
    wire logic sel_one = (32'(phase_sel_in) < NPH);
    wire logic gain_ok = (wr_val >= 0) && (wr_val <= $signed(GAIN_MAX_Q));
    wire logic ofs_ok  = (wr_val <= $signed(OFS_MAX)) && (wr_val >= -$signed(OFS_MAX))
                         && (sel_all || sel_one);                             // [R10]
    wire logic bad_wr  = (wr_gain & ~gain_ok) | (wr_ofs & ~ofs_ok) | (wr_ovf & ~map_ok); // [R04]
    wire logic [10:0] split_man = 11'($signed(cmd_data_in[10:0]) / NPH);       // [R12]
    wire logic [15:0] all_rd    = {ofs_q[0][15:11],
                                   sat11(VAL_W'($signed(ofs_q[0][10:0])) * NPH)}; // [R13]
    wire logic [10:0] gain_rnd  = sat11((gain_val + $signed(GAIN_RND)) >>> GAIN_RND_SH);
    wire logic [10:0] gain_cap  = (gain_rnd > GAIN_Q_MAN_MAX) ? GAIN_Q_MAN_MAX : gain_rnd;
    wire logic [15:0] gain_step = {GAIN_Q_EXP, gain_cap};                      // [R05]

    icv_lin11_dec u_wr_dec   (.word_in(cmd_data_in), .value_out(wr_val));
    icv_lin11_dec u_gain_dec (.word_in(gain_q),      .value_out(gain_val));

    // one decoder per phase offset
    for (genvar p = 0; p < NPH; p++) begin : g_ofs_dec
        icv_lin11_dec u_dec (.word_in(ofs_q[p]), .value_out(ofs_val[p]));
    end

    icv_ov_map u_map (
        .limit_in       (cmd_data_in),
        .vout_cmd_in    (vout_command_in),
        .abs_mode_in    (vout_abs_mode_in),
        .fine_idx_out   (map_fine),
        .coarse_idx_out (map_coarse),
        .valid_out      (map_ok)
    );

    // gain: restore beats store beats a live write; live writes stay unrounded
    always_comb begin
        gain_d = gain_q;
        gain_nvm_d = gain_nvm_q;
        if (nvm_restore_in) begin
            gain_d = gain_nvm_q;                      // [R05]
        end else if (nvm_store_in) begin
            gain_d = gain_step;                       // [R05]
            gain_nvm_d = gain_step;
        end else if (wr_gain && gain_ok) begin
            gain_d = cmd_data_in;                     // [R06]
        end
    end

    // per-phase offsets, same priority as the gain
    always_comb begin
        for (int p = 0; p < NPH; p++) begin
            ofs_d[p] = ofs_q[p];
            ofs_nvm_d[p] = ofs_nvm_q[p];
            if (nvm_restore_in) begin
                ofs_d[p] = ofs_nvm_q[p];              // [R09]
            end else if (nvm_store_in) begin
                ofs_nvm_d[p] = {OFS_Q_EXP, sat11((ofs_val[p] + $signed(OFS_RND)) >>> OFS_RND_SH)}; // [R09]
            end else if (wr_ofs && ofs_ok) begin
                if (sel_all) begin
                    ofs_d[p] = {cmd_data_in[15:11], split_man};          // [R12]
                end else if (32'(phase_sel_in) == p) begin
                    ofs_d[p] = cmd_data_in;                              // [R11]
                end
            end
        end
    end

    // offset sum and gain-scaled report; the sum truncates beyond 32 bits
    logic signed [VAL_W-1:0] ofs_sum;
    always_comb begin
        ofs_sum = '0;
        for (int p = 0; p < NPH; p++) begin
            ofs_sum = ofs_sum + ofs_val[p];           // [R08]
        end
    end
    wire logic signed [50:0] iout_prod = 51'($signed(iout_sense_in) *
                                              $signed({1'b0, gain_val[GAIN_USE_W-1:0]}));
    wire logic signed [31:0] report_d  = 32'(iout_prod >>> FRAC) + ofs_sum[31:0]; // [R01] [R07]

    // overvoltage threshold follows the present command, not the stored word
    wire logic [10:0] pct_act  = converting_in ? pct_fine(fine_q) : pct_coarse(coarse_q); // [R19]
    wire logic [31:0] sense_k  = 32'({16'h0000, vout_sense_in} * PCT_SCALE);
    wire logic [31:0] thr_k    = 32'({16'h0000, vout_command_in} * {21'h0, pct_act}); // [R14] [R15]
    wire logic        ov_now   = sense_k > thr_k;     // [R16]
    wire logic        ov_event = ov_now & ~ov_now_q;
    wire logic [1:0]  resp     = ov_response_in[RESP_HI:RESP_LO];
    wire logic        resp_off = (resp != RESP_IGNORE) && (resp != RESP_INVALID);

    // overvoltage watch: flag every new fault, hold off until faults are cleared
    always_comb begin
        ovs_d = ovs_q;
        case (ovs_q)
            OVS_WATCH: if (ov_event) ovs_d = OVS_FLAG;
            OVS_FLAG:  if (resp_off) ovs_d = OVS_OFF;                    // [R17]
                       else if (!ov_now) ovs_d = OVS_WATCH;
            OVS_OFF:   if (clear_faults_in && !ov_now) ovs_d = OVS_WATCH;
            default:   ovs_d = OVS_WATCH;
        endcase
    end

    // register state; all outputs are flops
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            gain_q <= GAIN_RESET;                     // [R02]
            gain_nvm_q <= GAIN_RESET;
            ofs_q <= '{default: OFS_RESET};
            ofs_nvm_q <= '{default: OFS_RESET};
            ovf_q <= OVF_RESET;
            fine_q <= FINE_RESET;
            coarse_q <= COARSE_RESET;
            ovs_q <= OVS_WATCH;
        end else begin
            gain_q <= gain_d;
            gain_nvm_q <= gain_nvm_d;
            ofs_q <= ofs_d;
            ofs_nvm_q <= ofs_nvm_d;
            ovs_q <= ovs_d;
            if (wr_ovf && map_ok) begin
                ovf_q <= cmd_data_in;                 // [R15]
                fine_q <= map_fine;                   // [R18]
                coarse_q <= map_coarse;
            end
        end
    end

    // status flags: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            ov_now_q <= 1'b0;
            shut_q <= 1'b0;
            st_ov_q <= 1'b0;
            st_cml_q <= 1'b0;
            alert_q <= 1'b0;
        end else begin
            ov_now_q <= ov_now;
            shut_q <= (ovs_d == OVS_OFF);             // [R17]
            st_ov_q <= ov_event | (st_ov_q & ~clear_faults_in);   // [R20]
            st_cml_q <= bad_wr | (st_cml_q & ~clear_faults_in);   // [R04]
            // alert is its own flop so the pin never glitches on the flag merge
            alert_q <= ov_event | bad_wr | ((st_ov_q | st_cml_q) & ~clear_faults_in); // [R20]
        end
    end

    // read path and telemetry outputs
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 16'h0000;
            iout_report_out <= 32'h0000_0000;
            offset_sum_out <= 32'h0000_0000;
            oc_fault_out <= 1'b0;
            oc_warn_out <= 1'b0;
            ov_pct_out <= PCT_CRS_BASE;
        end else begin
            rd_valid_out <= cmd_valid_in & ~cmd_write_in;
            rd_data_out <= 16'h0000;
            if (cmd_valid_in && !cmd_write_in) begin
                case (cmd_code_in)
                    CMD_GAIN:   rd_data_out <= gain_q;
                    CMD_OFFSET: rd_data_out <= sel_all ? all_rd :          // [R13]
                                               sel_one ? ofs_q[phase_sel_in[1:0]] : 16'h0000; // [R11]
                    CMD_OVF:    rd_data_out <= ovf_q;
                    default:    rd_data_out <= 16'h0000;
                endcase
            end
            iout_report_out <= report_d;
            offset_sum_out <= ofs_sum[31:0];
            oc_fault_out <= report_d > $signed(oc_fault_limit_in);   // [R03]
            oc_warn_out <= report_d > $signed(oc_warn_limit_in);     // [R03]
            ov_pct_out <= pct_act;
        end
    end

    assign ov_fault_out = ov_now_q;
    assign ov_shutdown_out = shut_q;
    assign status_byte_ov_out = st_ov_q;
    assign status_word_vout_out = st_ov_q;
    assign status_overvoltage_limit_value_out = st_ov_q;
    assign status_cml_out = st_cml_q;
    assign alert_out = alert_q;                       // [R20]

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_ff_write;
        wr_ofs && ofs_ok && sel_all && !nvm_restore_in && !nvm_store_in;
    endsequence
    sequence s_ov_rise;
        ov_now && !ov_now_q;
    endsequence

    a_gain_reset_one: assert property ($rose(nrst_in) |-> gain_val == 48'sh10000) // [R02]
        else $error("gain trim not one after reset");
    a_bad_gain_kept: assert property (wr_gain && !gain_ok && !nvm_restore_in && !nvm_store_in
        |=> $stable(gain_q) && status_cml_out && alert_out) // [R04]
        else $error("invalid gain write not refused");
    a_ff_write_split: assert property (s_ff_write |=> ofs_q[NPH-1][10:0] == $past(split_man)) // [R12]
        else $error("split offset wrong");
    a_ff_read_scale: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == CMD_OFFSET
        && sel_all |=> rd_valid_out && rd_data_out == $past(all_rd)) // [R13]
        else $error("all-phase read wrong");
    a_phase_only: assert property (wr_ofs && ofs_ok && phase_sel_in == 8'h01 && !nvm_restore_in
        |=> $stable(ofs_q[0])) // [R11]
        else $error("other phase disturbed");
    a_gain_store_cap: assert property (nvm_store_in && !nvm_restore_in
        |=> gain_q[15:11] == GAIN_Q_EXP && gain_q[10:0] <= GAIN_Q_MAN_MAX) // [R05]
        else $error("stored gain not quantised");
    a_ov_status_set: assert property (s_ov_rise |=> status_byte_ov_out && status_overvoltage_limit_value_out
        && status_word_vout_out && alert_out) // [R20]
        else $error("overvoltage status missing");
    a_ov_ignore: assert property (s_ov_rise && !ov_shutdown_out ##1 (resp == RESP_IGNORE)[*2]
        |=> !ov_shutdown_out) // [R17]
        else $error("shutdown despite ignore");
    a_ov_stopped: assert property (!converting_in |=> ov_pct_out >= PCT_CRS_BASE) // [R19]
        else $error("stopped threshold below 110 percent");
endmodule : icv_regs

// ===== tb/icv_host_model.sv
// host side of the decoded command port: one read or write word per call
`timescale 1ns/1ps
module icv_host_model (
    input  wire logic        clk_in,      // bench clock
    input  wire logic        rd_valid_in, // read answer strobe
    input  wire logic [15:0] rd_data_in,  // read answer word
    output logic             valid_out = 1'b0,    // command strobe
    output logic             write_out = 1'b0,    // write flag
    output logic [7:0]       code_out  = 8'h00,   // command code
    output logic [15:0]      data_out  = 16'h0000, // write word
    output logic [7:0]       phase_out = 8'h00    // phase selector
);
    // the answer is taken at the edge after the command edge, then the strobe drops;
    // the idle data word is inverted so a stale value never looks fresh
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        input logic [7:0] p, output logic [15:0] rd, output logic v);
        @(posedge clk_in);
        #1;
        valid_out = 1'b1;
        write_out = w;
        code_out  = c;
        data_out  = d;
        phase_out = p;
        @(posedge clk_in);
        #1;
        v  = rd_valid_in;
        rd = rd_data_in;
        valid_out = 1'b0;
        data_out  = ~d;
    endtask : xfer
endmodule : icv_host_model

// ===== tb/icv_regs_tb_top.sv
// self-checking bench for the current trim and overvoltage limit registers
`timescale 1ns/1ps
module icv_regs_tb_top;
    import icv_pkg::*;
    logic        ref_clk_in = 1'b0, nrst_in = 1'b0, converting_in = 1'b1;
    logic        nvm_store_in = 1'b0, nvm_restore_in = 1'b0, clear_faults_in = 1'b0;
    logic        vout_abs_mode_in = 1'b0, cmd_valid_in, cmd_write_in, v;
    logic        rd_valid_out, oc_fault_out, oc_warn_out, ov_fault_out, ov_shutdown_out;
    logic        status_byte_ov_out, status_word_vout_out, status_overvoltage_limit_value_out;
    logic        status_cml_out, alert_out;
    logic [7:0]  cmd_code_in, phase_sel_in, ov_response_in = 8'h40;
    logic [10:0] ov_pct_out;
    logic [15:0] vout_command_in = 16'h0400, vout_sense_in = 16'h0000;
    logic [15:0] cmd_data_in, rd_data_out, rd;
    logic [31:0] iout_sense_in = 32'h0001_0000, oc_fault_limit_in = 32'h0001_0100;
    logic [31:0] oc_warn_limit_in = 32'h0002_0000, iout_report_out, offset_sum_out;
    int          error_cnt = 0, num_checks = 0, cyc = 0;

    icv_regs u_icv_regs (.ref_clk_in, .nrst_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in,
        .cmd_data_in, .phase_sel_in, .nvm_store_in, .nvm_restore_in, .clear_faults_in,
        .iout_sense_in, .oc_fault_limit_in, .oc_warn_limit_in, .vout_abs_mode_in,
        .vout_command_in, .vout_sense_in, .converting_in, .ov_response_in, .rd_data_out,
        .rd_valid_out, .iout_report_out, .offset_sum_out, .oc_fault_out, .oc_warn_out,
        .ov_pct_out, .ov_fault_out, .ov_shutdown_out, .status_byte_ov_out,
        .status_word_vout_out, .status_overvoltage_limit_value_out, .status_cml_out, .alert_out);
    icv_host_model u_icv_host_model (.clk_in(ref_clk_in), .rd_valid_in(rd_valid_out),
        .rd_data_in(rd_data_out), .valid_out(cmd_valid_in), .write_out(cmd_write_in),
        .code_out(cmd_code_in), .data_out(cmd_data_in), .phase_out(phase_sel_in));

    // 100 MHz clock; the run needs under a hundred cycles, so 3000 means a hang
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one command; the answer strobe must follow reads and never writes
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [7:0] p);
        u_icv_host_model.xfer(w, c, d, p, rd, v);
        chk("rd_valid_out", 32'(!w), 32'(v));
    endtask : acc

    task automatic rdc(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e,
                       input string nm);
        acc(1'b0, c, 16'h0000, p);
        chk(nm, 32'(e), 32'(rd));
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : idle

    task automatic pulse(ref logic s);
        s = 1'b1;
        idle(1);
        s = 1'b0;
    endtask : pulse

    task automatic t_reset;
        rdc(CMD_GAIN, 8'h00, 16'hC880, "gain reset");
        rdc(CMD_OVF, 8'h00, 16'h0266, "limit reset");
        rdc(CMD_OFFSET, 8'h00, 16'hE000, "offset reset");
        chk("ov_pct_out", 32'h4B0, 32'(ov_pct_out));
        chk("oc_fault_out", 32'h0, 32'(oc_fault_out));
    endtask : t_reset

    // fine gain kept live, bad gain refused, store rounds to 1/64 steps
    task automatic t_gain;
        acc(1'b1, CMD_GAIN, 16'hC881, 8'h00);
        rdc(CMD_GAIN, 8'h00, 16'hC881, "gain fine");
        chk("iout_report_out", 32'h0001_0200, iout_report_out);
        chk("oc flags", 32'h2, 32'({oc_fault_out, oc_warn_out}));
        acc(1'b1, CMD_GAIN, 16'hCF80, 8'h00);
        idle(1);
        chk("status_cml_out", 32'h1, 32'(status_cml_out));
        rdc(CMD_GAIN, 8'h00, 16'hC881, "gain kept");
        pulse(clear_faults_in);
        acc(1'b1, CMD_GAIN, 16'hC103, 8'h00);
        pulse(nvm_store_in);
        rdc(CMD_GAIN, 8'h00, 16'hD041, "gain stored");
    endtask : t_gain

    task automatic t_offset;
        acc(1'b1, CMD_OFFSET, 16'hE008, PHASE_ALL);
        rdc(CMD_OFFSET, 8'h01, 16'hE002, "phase share");
        rdc(CMD_OFFSET, PHASE_ALL, 16'hE008, "stack total");
        acc(1'b1, CMD_OFFSET, 16'hE004, 8'h01);
        rdc(CMD_OFFSET, 8'h00, 16'hE002, "phase 0 kept");
        chk("offset_sum_out", 32'h0000_A000, offset_sum_out);
        chk("iout_report_out", 32'h0001_A400, iout_report_out);
        pulse(nvm_store_in);
        acc(1'b1, CMD_OFFSET, 16'h0011, 8'h00);
        idle(1);
        chk("status_cml_out", 32'h1, 32'(status_cml_out));
        pulse(clear_faults_in);
        acc(1'b1, CMD_OFFSET, 16'hE000, 8'h01);
        pulse(nvm_restore_in);
        rdc(CMD_OFFSET, 8'h01, 16'hE004, "phase restored");
    endtask : t_offset

    // 121.875 % rounds up per mode; the compare still runs with conversion off
    task automatic t_ov;
        acc(1'b1, CMD_OVF, 16'h0270, 8'h00);
        idle(1);
        chk("ov_pct_out", 32'h4C9, 32'(ov_pct_out));
        converting_in = 1'b0;
        idle(2);
        chk("ov_pct_out", 32'h514, 32'(ov_pct_out));
        acc(1'b1, CMD_OVF, 16'h0300, 8'h00);
        idle(1);
        chk("status_cml_out", 32'h1, 32'(status_cml_out));
        pulse(clear_faults_in);
        vout_sense_in = 16'h0530;
        idle(3);
        chk("ov_fault_out", 32'h0, 32'(ov_fault_out));
        vout_sense_in = 16'h0540;
        idle(3);
        chk("ov flags", 32'h3F, 32'({ov_fault_out, ov_shutdown_out, status_byte_ov_out,
            status_word_vout_out, status_overvoltage_limit_value_out, alert_out}));
        vout_abs_mode_in = 1'b1;
        acc(1'b1, CMD_OVF, 16'h0500, 8'h00);
        vout_command_in = 16'h0480;
        rdc(CMD_OVF, 8'h00, 16'h0500, "abs word kept");
        // 130 % of the new command sits above 0580h; ignore must not shut down
        vout_sense_in = 16'h0000;
        ov_response_in = 8'h00;
        pulse(clear_faults_in);
        chk("ov_shutdown_out", 32'h0, 32'(ov_shutdown_out));
        vout_sense_in = 16'h0580;
        idle(3);
        chk("ov_fault_out", 32'h0, 32'(ov_fault_out));
        vout_sense_in = 16'h0600;
        idle(3);
        chk("ov ignore", 32'h2, 32'({ov_fault_out, ov_shutdown_out}));
    endtask : t_ov

    task automatic tally_and_finish;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        idle(6);
        nrst_in = 1'b1;
        t_reset();
        t_gain();
        t_offset();
        t_ov();
        tally_and_finish();
    end
endmodule : icv_regs_tb_top
